// File: src/vhsr_core.sv
// voice highway slot receive block: serial highway/GCI receive, transmit
// slot drive with signaling byte, robbed-bit detect and scaling decode.
// assumes line pins are asynchronous to sys_clk and far slower than it.
//
// Contract
// - channel pins choose the accepted GCI channel
// - voice bytes to expander, monitor/SC aside
// - GCI marker is channel 0 reference
// - GCI data always fixed 2.048 MHz rate
// - scaling gain is 0.0625 gain times code-16
// - code zero cuts scaling path off
// - code 10000 gives full digital loopback
// - loopback ignores input, output at reference
// - A or mu law, A-law inverts alternate bits
// - linear is 16-bit, sign first, two slots
// - double clock halves the PCM data rate
// - divide by two stays inside slot logic
// - signaling mode: voice slot then signaling slot
// - signaling byte: hook, detect, clock failure
// - signaling bit 7 follows voice bit 0
// - signaling slot driven even when inactive
// - robbed bit only mu-law receive path
// - robbed LSB replaced by half weight
// - robbed frame needs enable, mu-law, not-2-then-2
// - frame sync sampled on falling clock edges
// - substitution only in slots of robbed frames
// - highway frame sync marks slot 0
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vhsr_core
   import vhsr_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output var  logic [31:0]       reg_rdata,
   // line pins, asynchronous
   input  wire logic              line_bit_clock,
   input  wire logic              highway_frame_sync,
   input  wire logic              highway_receive_data,
   input  wire logic              gci_frame_marker,
   input  wire logic              downstream_serial_line,
   input  wire logic              gci_channel_select_lo,
   input  wire logic              gci_channel_select_hi,
   output var  logic              highway_transmit_data,
   output var  logic              highway_transmit_oe,
   // line supervision inputs, asynchronous
   input  wire logic              hook_detect_input,
   input  wire logic              second_detect_input,
   input  wire logic              multiplexed_detect_input,
   input  wire logic              clock_failure_flag,
   // transmit samples from the compressor
   input  wire logic [7:0]        tx_voice_byte,
   input  wire logic [15:0]       tx_linear_word,
   // receive samples and GCI control bytes
   output var  vhsr_rx_t          rx_sample,
   output var  logic [7:0]        gci_monitor_byte,
   output var  logic [7:0]        gci_sc_byte,
   output var  logic              gci_ctrl_valid,
   // analog side controls
   output var  vhsr_impedance_scaling_code_t        impedance_scaling_code_ctrl,
   output var  logic              analog_input_ignore,
   output var  logic              analog_output_to_ref,
   output var  logic              dsp_clock_from_line
);

   // undo or apply alternate bit inversion; identical both ways
   function automatic logic [7:0] abi(input logic [7:0] b, input logic al);
      abi = al ? (b ^ VHSR_ABI_MASK) : b;
   endfunction

   vhsr_ctrl_t  ctrl_q;
   logic [6:0]  rx_slot_q;
   logic [6:0]  tx_slot_q;
   logic [4:0]  impedance_scaling_code_code_q;
   logic [8:0]  sync1_q;
   logic [8:0]  sync2_q;
   logic        clk_prev_q;
   logic        fs_prev_q;
   logic [1:0]  fs_run_q;
   logic        prev_len2_q;
   logic        robbed_q;
   logic        half_q;
   logic [9:0]  pos_q;
   logic [7:0]  shift_q;
   logic [7:0]  hi_byte_q;
   logic [15:0] tx_word_q;
   logic [15:0] last_word_q;

   // synchronised pins: two flops before any logic looks at them
   logic s_clk, s_fs, s_din, s_sel_lo, s_sel_hi;
   logic s_hook, s_det2, s_detm, s_clock_failure_flag;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
      end else begin
         sync1_q <= {line_bit_clock, highway_frame_sync, highway_receive_data,
                     gci_frame_marker, downstream_serial_line,
                     gci_channel_select_lo, gci_channel_select_hi,
                     hook_detect_input, second_detect_input};
         sync2_q <= sync1_q;
      end
   end
   assign s_clk    = sync2_q[8];
   assign s_sel_lo = sync2_q[3];
   assign s_sel_hi = sync2_q[2];
   assign s_hook   = sync2_q[1];
   assign s_det2   = sync2_q[0];
   // GCI uses its own marker and line, highway mode the PCM pins
   assign s_fs  = ctrl_q.gci_mode ? sync2_q[5] : sync2_q[7];
   assign s_din = ctrl_q.gci_mode ? sync2_q[4] : sync2_q[6];

   // slow supervision levels caught separately
   logic [1:0] sup1_q;
   logic [1:0] sup2_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sup1_q <= 2'h0;
         sup2_q <= 2'h0;
      end else begin
         sup1_q <= {multiplexed_detect_input, clock_failure_flag};
         sup2_q <= sup1_q;
      end
   end
   assign s_detm  = sup2_q[1];
   assign s_clock_failure_flag = sup2_q[0];

   // edge detection on the synchronised bit clock
   logic fall, fs_start, div_mode, tick;
   assign fall     = clk_prev_q & ~s_clk;
   assign fs_start = fall & s_fs & ~fs_prev_q;
   // GCI line clock is always twice its fixed data rate
   assign div_mode = ctrl_q.gci_mode | ctrl_q.double_clock_mode;
   assign tick     = fall & (~div_mode | half_q | fs_start);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk_prev_q <= 1'b0;
         fs_prev_q  <= 1'b0;
      end else begin
         clk_prev_q <= s_clk;
         if (fall)
            fs_prev_q <= s_fs;
      end
   end

   // divide by two lives only here, so the DSP clock path never sees it
   always_ff @(posedge sys_clk) begin
      if (rst)
         half_q <= 1'b0;
      else if (fs_start)
         half_q <= 1'b0;
      else if (fall)
         half_q <= ~half_q;
   end

   // frame sync width measured over falling edges
   logic len2;
   assign len2 = (fs_run_q == VHSR_RB_LEN);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fs_run_q    <= 2'h0;
         prev_len2_q <= 1'b0;
         robbed_q    <= 1'b0;
      end else if (fall) begin
         if (s_fs) begin
            if (~fs_prev_q)
               fs_run_q <= 2'h1;
            else if (fs_run_q != 2'h3)
               fs_run_q <= fs_run_q + 2'h1;
         end else if (fs_prev_q) begin
            // pulse just ended: decide once, hold until next pulse ends
            prev_len2_q <= len2;
            robbed_q    <= ctrl_q.robbed_bit_enable & ~ctrl_q.a_law &
                           ~ctrl_q.linear & ~ctrl_q.gci_mode &
                           len2 & ~prev_len2_q;
         end
      end
   end

   // bit position inside the frame; frame sync edge is bit 0 of slot 0
   logic [9:0] pos;
   logic [9:0] nxt;
   assign pos = fs_start ? 10'h000 : pos_q;
   assign nxt = pos + 10'h001;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pos_q   <= 10'h000;
         shift_q <= 8'h00;
      end else if (tick) begin
         pos_q   <= nxt;
         shift_q <= {shift_q[6:0], s_din};
      end
   end

   // byte completion and routing
   logic [7:0] byte_in;
   logic       byte_done;
   logic [6:0] slot;
   logic       gci_mine;
   assign byte_in   = {shift_q[6:0], s_din};
   assign byte_done = tick & (pos[2:0] == 3'h7);
   assign slot      = pos[9:3];
   assign gci_mine  = (pos[9:5] == {3'h0, s_sel_hi, s_sel_lo});

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_sample        <= '0;
         hi_byte_q        <= 8'h00;
         gci_monitor_byte <= 8'h00;
         gci_sc_byte      <= 8'h00;
         gci_ctrl_valid   <= 1'b0;
         last_word_q      <= 16'h0000;
      end else begin
         rx_sample.valid <= 1'b0;
         gci_ctrl_valid  <= 1'b0;
         if (byte_done && ctrl_q.gci_mode && gci_mine) begin
            unique case (pos[4:3])
               2'h0, 2'h1: begin
                  // both voice bytes go to the expander
                  rx_sample   <= {1'b1, 1'b0, 1'b0, 8'h00,
                                  abi(byte_in, ctrl_q.a_law)};
                  last_word_q <= {8'h00, byte_in};
               end
               2'h2:
                  gci_monitor_byte <= byte_in;
               2'h3: begin
                  gci_sc_byte    <= byte_in;
                  gci_ctrl_valid <= 1'b1;
               end
            endcase
         end else if (byte_done && !ctrl_q.gci_mode &&
                      ctrl_q.channel_active) begin
            if (ctrl_q.linear) begin
               // high byte first, word handed over with the low byte
               if (slot == rx_slot_q)
                  hi_byte_q <= byte_in;
               else if (slot == rx_slot_q + 7'h01) begin
                  rx_sample   <= {1'b1, 1'b1, 1'b0, hi_byte_q, byte_in};
                  last_word_q <= {hi_byte_q, byte_in};
               end
            end else if (slot == rx_slot_q) begin
               // robbed frames: lsb dropped, expander adds half weight
               rx_sample <= {1'b1, 1'b0, robbed_q, 8'h00,
                             abi(byte_in, ctrl_q.a_law) &
                             {7'h7F, ~robbed_q}};
               last_word_q <= {8'h00, byte_in};
            end
         end
      end
   end

   // transmit word latched at frame start so a slot never tears
   logic [7:0] sig_byte;
   assign sig_byte = {s_hook,
                      ctrl_q.detect_mux_sel ? s_detm : s_det2,
                      3'h0, s_clock_failure_flag, 2'h0};
   always_ff @(posedge sys_clk) begin
      if (rst)
         tx_word_q <= 16'h0000;
      else if (fs_start)
         // transmit bytes never see robbed-bit handling
         tx_word_q <= ctrl_q.linear ? tx_linear_word
                      : {abi(tx_voice_byte, ctrl_q.a_law), sig_byte};
   end

   // transmit slot drive; signaling byte runs straight on from voice
   logic [9:0] tx_off;
   logic [4:0] tx_len;
   logic       in_win;
   logic       voice_half;
   assign tx_off  = nxt - {tx_slot_q, 3'h0};
   assign tx_len  = (ctrl_q.linear | ctrl_q.signaling_slot_mode)
                    ? VHSR_LEN_PAIR : VHSR_LEN_BYTE;
   assign in_win  = ({5'h00, tx_len} > tx_off);
   assign voice_half = (tx_off[3] == 1'b0);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         highway_transmit_data <= 1'b0;
         highway_transmit_oe   <= 1'b0;
      end else if (tick) begin
         // bit 7 of the second byte sits right after bit 0 of the first
         highway_transmit_data <= tx_word_q[4'hF - tx_off[3:0]];
         // an inactive channel still owns its signaling slot
         highway_transmit_oe <= ~ctrl_q.gci_mode & in_win &
                                (ctrl_q.channel_active | (~voice_half &
                                 ctrl_q.signaling_slot_mode &
                                 ~ctrl_q.linear));
      end
   end

   // impedance scaling decode, special codes first
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         impedance_scaling_code_ctrl            <= '0;
         analog_input_ignore  <= 1'b0;
         analog_output_to_ref <= 1'b0;
      end else begin
         impedance_scaling_code_ctrl.cutoff     <= (impedance_scaling_code_code_q == VHSR_IMPEDANCE_SCALING_CODE_CUTOFF);
         impedance_scaling_code_ctrl.loopback   <= (impedance_scaling_code_code_q == VHSR_IMPEDANCE_SCALING_CODE_LOOP);
         impedance_scaling_code_ctrl.gain_steps <= (impedance_scaling_code_code_q == VHSR_IMPEDANCE_SCALING_CODE_CUTOFF ||
                                  impedance_scaling_code_code_q == VHSR_IMPEDANCE_SCALING_CODE_LOOP) ? 6'h00
                                 : {1'b0, impedance_scaling_code_code_q} - VHSR_IMPEDANCE_SCALING_CODE_MID;
         analog_input_ignore  <= (impedance_scaling_code_code_q == VHSR_IMPEDANCE_SCALING_CODE_LOOP);
         analog_output_to_ref <= (impedance_scaling_code_code_q == VHSR_IMPEDANCE_SCALING_CODE_LOOP);
      end
   end

   // bit clock may also feed the DSP clock; undivided either way
   always_ff @(posedge sys_clk) begin
      if (rst)
         dsp_clock_from_line <= 1'b0;
      else
         dsp_clock_from_line <= ctrl_q.clock_source_select;
   end

   // register writes; software is trusted to set companded before
   // signaling, the block does not police it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_q      <= vhsr_ctrl_t'(VHSR_CTRL_RST);
         rx_slot_q   <= VHSR_SLOT_RST;
         tx_slot_q   <= VHSR_SLOT_RST;
         impedance_scaling_code_code_q <= VHSR_IMPEDANCE_SCALING_CODE_RST;
      end else if (reg_write) begin
         unique case (reg_addr)
            VHSR_CTRL_ADDR:
               ctrl_q <= vhsr_ctrl_t'(reg_wdata[VHSR_CTRL_W-1:0]);
            VHSR_SLOT_ADDR: begin
               rx_slot_q <= reg_wdata[VHSR_RX_SLOT_LSB +: VHSR_SLOT_W];
               tx_slot_q <= reg_wdata[VHSR_TX_SLOT_LSB +: VHSR_SLOT_W];
            end
            VHSR_IMPEDANCE_SCALING_CODE_ADDR:
               impedance_scaling_code_code_q <= reg_wdata[VHSR_IMPEDANCE_SCALING_CODE_W-1:0];
            default: ;
         endcase
      end
   end

   // read data stands one cycle after the strobe, else zero
   always_ff @(posedge sys_clk) begin
      if (rst)
         reg_rdata <= 32'h0000_0000;
      else if (reg_read) begin
         unique case (reg_addr)
            VHSR_CTRL_ADDR:   reg_rdata <= {23'h000000, ctrl_q};
            VHSR_SLOT_ADDR:   reg_rdata <= {17'h00000, tx_slot_q,
                                            1'b0, rx_slot_q};
            VHSR_IMPEDANCE_SCALING_CODE_ADDR:   reg_rdata <= {27'h0000000, impedance_scaling_code_code_q};
            VHSR_STATUS_ADDR: reg_rdata <= {8'h00, gci_sc_byte,
                                            gci_monitor_byte,
                                            6'h00, prev_len2_q, robbed_q};
            VHSR_RXDATA_ADDR: reg_rdata <= {16'h0000, last_word_q};
            default:          reg_rdata <= 32'h0000_0000;
         endcase
      end else
         reg_rdata <= 32'h0000_0000;
   end

endmodule // vhsr_core
`default_nettype wire

// File: shared/vhsr_pkg.sv
// package of the voice highway slot receive block: register map, field
// layout, reset values and the carriers shared by the design and the bench.
// assumes a 32-bit plain register port and one 100 MHz system clock.
`default_nettype none
package vhsr_pkg;
   // register byte addresses
   localparam logic [7:0]  VHSR_CTRL_ADDR   = 8'h00;
   localparam logic [7:0]  VHSR_SLOT_ADDR   = 8'h04;
   localparam logic [7:0]  VHSR_IMPEDANCE_SCALING_CODE_ADDR   = 8'h08;
   localparam logic [7:0]  VHSR_STATUS_ADDR = 8'h0C;
   localparam logic [7:0]  VHSR_RXDATA_ADDR = 8'h10;
   // field positions
   localparam int          VHSR_CTRL_W      = 9;
   localparam int          VHSR_RX_SLOT_LSB = 0;
   localparam int          VHSR_TX_SLOT_LSB = 8;
   localparam int          VHSR_SLOT_W      = 7;
   localparam int          VHSR_IMPEDANCE_SCALING_CODE_W      = 5;
   // reset values
   localparam logic [8:0]  VHSR_CTRL_RST    = 9'h000;
   localparam logic [6:0]  VHSR_SLOT_RST    = 7'h00;
   localparam logic [4:0]  VHSR_IMPEDANCE_SCALING_CODE_RST    = 5'h00;
   // coding constants
   localparam logic [7:0]  VHSR_ABI_MASK    = 8'h55;
   localparam logic [4:0]  VHSR_IMPEDANCE_SCALING_CODE_CUTOFF = 5'h00;
   localparam logic [4:0]  VHSR_IMPEDANCE_SCALING_CODE_LOOP   = 5'h10;
   localparam logic [5:0]  VHSR_IMPEDANCE_SCALING_CODE_MID    = 6'h10;
   localparam logic [1:0]  VHSR_RB_LEN      = 2'h2;
   localparam logic [4:0]  VHSR_LEN_BYTE    = 5'h08;
   localparam logic [4:0]  VHSR_LEN_PAIR    = 5'h10;

   // control register layout, msb first
   typedef struct packed {
      logic detect_mux_sel;       // 1: multiplexed detect in bit 6
      logic channel_active;
      logic robbed_bit_enable;
      logic signaling_slot_mode;
      logic clock_source_select;
      logic double_clock_mode;
      logic linear;
      logic a_law;
      logic gci_mode;
   } vhsr_ctrl_t;

   // one received sample handed to the expander or the signal path
   typedef struct packed {
      logic        valid;
      logic        linear;
      logic        half_lsb;
      logic [15:0] word;
   } vhsr_rx_t;

   // impedance scaling decode
   typedef struct packed {
      logic       cutoff;
      logic       loopback;
      logic [5:0] gain_steps;     // signed, units of 0.0625 x input gain
   } vhsr_impedance_scaling_code_t;
endpackage : vhsr_pkg
`default_nettype wire

// File: tb/vhsr_core_sva.sv
// checker of the slot receive block: register answers, scaling decode and
// receive strobes. assumes it is bound to vhsr_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module vhsr_chk
   import vhsr_pkg::*;
(
   // clock, reset and register port
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   // decoded outputs
   input wire vhsr_rx_t    rx_sample,
   input wire logic        gci_ctrl_valid,
   input wire vhsr_impedance_scaling_code_t  impedance_scaling_code_ctrl,
   input wire logic        analog_input_ignore,
   input wire logic        analog_output_to_ref,
   input wire logic        dsp_clock_from_line
);
   logic [4:0] code_q;
   logic [1:0] age_q;

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // last scaling code and its age; judged only once the decode has settled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         code_q <= 5'h00;
         age_q  <= 2'h3;
      end else if (reg_write && reg_addr == VHSR_IMPEDANCE_SCALING_CODE_ADDR) begin
         code_q <= reg_wdata[4:0];
         age_q  <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q  <= age_q + 2'h1;
      end
   end

   impedance_scaling_code_gain_a : assert property (
      age_q == 2'h2 && code_q != 5'h00 && code_q != 5'h10 |->
      impedance_scaling_code_ctrl == {2'b00, {1'b0, code_q} - VHSR_IMPEDANCE_SCALING_CODE_MID})
      else $error("scaling gain does not follow the code");
   impedance_scaling_code_cutoff_a : assert property (
      age_q == 2'h2 && code_q == VHSR_IMPEDANCE_SCALING_CODE_CUTOFF |-> impedance_scaling_code_ctrl == 8'h80)
      else $error("zero code does not cut the scaling path");
   impedance_scaling_code_loop_a : assert property (
      age_q == 2'h2 && code_q == VHSR_IMPEDANCE_SCALING_CODE_LOOP |-> impedance_scaling_code_ctrl == 8'h40)
      else $error("loop code does not select digital loopback");
   loop_analog_a : assert property (
      age_q == 2'h2 |-> analog_input_ignore == (code_q == VHSR_IMPEDANCE_SCALING_CODE_LOOP)
      && analog_output_to_ref == analog_input_ignore)
      else $error("analog controls disagree with the loopback code");
   half_lsb_a : assert property (
      rx_sample.valid && rx_sample.half_lsb |->
      !rx_sample.word[0] && !rx_sample.linear)
      else $error("half weight flag without a cleared lsb");
   rx_pulse_a : assert property (
      rx_sample.valid |=> !rx_sample.valid)
      else $error("receive strobe longer than one cycle");
   ctrl_pulse_a : assert property (
      gci_ctrl_valid |=> !gci_ctrl_valid)
      else $error("control byte strobe longer than one cycle");
   clock_copy_a : assert property (
      reg_write && reg_addr == VHSR_CTRL_ADDR |->
      ##2 dsp_clock_from_line == $past(reg_wdata[4], 2))
      else $error("dsp clock source does not follow the control write");
   rdata_idle_a : assert property (
      !reg_read |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
endmodule // vhsr_chk

bind vhsr_core vhsr_chk chk_u (.*);
`default_nettype wire

// File: tb/vhsr_hw_model.sv
// highway switch model: drives bit clock, frame pulse and serial bits, and
// gathers what the block drives while its output enable is high.
// assumes the bench calls frame() from its main sequence, one at a time.
`timescale 1ns/1ps
`default_nettype none
module vhsr_hw_model (
   // line pins toward the block
   output var logic  line_bit_clock,
   output var logic  highway_frame_sync,
   output var logic  highway_receive_data,
   output var logic  gci_frame_marker,
   output var logic  downstream_serial_line,
   // transmit pins from the block
   input  wire logic highway_transmit_data,
   input  wire logic highway_transmit_oe
);
   logic [31:0] tx_bits = 32'h0;
   int          tx_cnt = 0;

   // clock parked high between frames so no fall is seen outside them
   initial begin
      line_bit_clock = 1'b1;
      {highway_frame_sync, highway_receive_data} = 2'b00;
      {gci_frame_marker, downstream_serial_line} = 2'b00;
   end

   // a lead-in fall with the pulse low, then run falls with it high;
   // bits change after the rise and hold div falls each
   task automatic frame(input logic gci, input int run, input int div,
                        input int nbits, input logic [63:0] pay);
      logic d;
      logic fs;
      #3;
      tx_cnt = 0;
      tx_bits = 32'h0;
      for (int g = 0; g <= nbits * div; g++) begin
         line_bit_clock = 1'b1;
         d = (g == 0) ? 1'b0 : pay[63 - (g - 1) / div];
         fs = (g >= 1 && g <= run);
         {highway_frame_sync, highway_receive_data} = gci ? 2'b00 : {fs, d};
         {gci_frame_marker, downstream_serial_line} = gci ? {fs, d} : 2'b00;
         #40;
         if (highway_transmit_oe === 1'b1) begin
            tx_bits = {tx_bits[30:0], highway_transmit_data};
            tx_cnt++;
         end
         line_bit_clock = 1'b0;
         #40;
      end
      // released data lines show the inverse of the last bit, not a hold
      line_bit_clock = 1'b1;
      {highway_frame_sync, gci_frame_marker} = 2'b00;
      highway_receive_data = ~highway_receive_data;
      downstream_serial_line = ~downstream_serial_line;
   endtask
endmodule // vhsr_hw_model
`default_nettype wire

// File: tb/voice_highway_slot_receive_signaling_test.sv
// bench of the slot receive block: register tasks, highway frames from
// the switch model, receive and transmit checks. assumes package and model.
`timescale 1ns/1ps
`default_nettype none
module voice_highway_slot_receive_signaling_test
   import vhsr_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic        gci_channel_select_lo = 1'b0;
   logic        gci_channel_select_hi = 1'b0;
   logic        hook_detect_input = 1'b1;
   logic        second_detect_input = 1'b0;
   logic        multiplexed_detect_input = 1'b1;
   logic        clock_failure_flag = 1'b1;
   logic [7:0]  tx_voice_byte = 8'h3C;
   logic [15:0] tx_linear_word = 16'h1234;
   logic [31:0] reg_rdata;
   logic [7:0]  gci_monitor_byte, gci_sc_byte;
   logic        gci_ctrl_valid, analog_input_ignore, analog_output_to_ref;
   logic        dsp_clock_from_line, highway_transmit_data;
   logic        highway_transmit_oe, line_bit_clock, highway_frame_sync;
   logic        highway_receive_data, gci_frame_marker, downstream_serial_line;
   vhsr_rx_t    rx_sample, s;
   vhsr_impedance_scaling_code_t  impedance_scaling_code_ctrl;
   vhsr_rx_t    rxq[$];
   int          mismatches = 0;
   int          n_tests = 0;
   int          n_ctrl = 0;
   logic [31:0] v;
   logic [4:0]  c;
   logic [5:0]  g;
   logic [4:0]  codes[6] = '{5'h00, 5'h10, 5'h01, 5'h0F, 5'h11, 5'h1F};

   vhsr_core dut_u (.*);
   vhsr_hw_model m_u (.*);

   // 100 MHz system clock
   always #5 sys_clk = ~sys_clk;

   // collect strobes as they pulse; each stands for one cycle only
   always @(posedge sys_clk) begin
      if (rx_sample.valid === 1'b1)
         rxq.push_back(rx_sample);
      if (gci_ctrl_valid === 1'b1)
         n_ctrl++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // register cycles: strobes last one cycle, read data in the next one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // one 32-bit frame, payload in slots 0 and 1; a companded sample is judged on its low byte
   task automatic rx(input int run, input int div, input logic [15:0] pay,
                     input logic [17:0] exp);
      rxq.delete();
      m_u.frame(1'b0, run, div, 32, {pay, 48'h0});
      repeat (8) @(posedge sys_clk);
      check(rxq.size(), 1);
      s = (rxq.size() > 0) ? rxq[0] : '0;
      check({s.half_lsb, s.linear,
             s.linear ? s.word : {8'h00, s.word[7:0]}}, exp);
   endtask

   // one frame, then the bits seen while the output enable was high
   task automatic txf(input int n, input logic [15:0] exp);
      m_u.frame(1'b0, 1, 1, 32, 64'h0);
      check(m_u.tx_cnt, n);
      check(m_u.tx_bits[15:0], exp);
   endtask

   // cut a hang short; the sequence needs well under 100 us
   initial begin
      #500_000;
      mismatches++;
      summarize();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      // every mapped register and the unmapped place 0x14 read zero after reset
      for (int a = 0; a < 24; a += 4) begin
         rd(8'(a), v);
         check(v, 32'h0);
      end
      wr(VHSR_SLOT_ADDR, 32'hFFFF_FFFF);
      wr(8'h14, 32'hFFFF_FFFF);
      rd(VHSR_SLOT_ADDR, v);
      check(v, 32'h0000_7F7F);
      rd(8'h14, v);
      check(v, 32'h0);
      // scaling codes: both special codes, the extremes and the two codes beside the midpoint
      foreach (codes[i]) begin
         c = codes[i];
         wr(VHSR_IMPEDANCE_SCALING_CODE_ADDR, {27'h0, c});
         repeat (3) @(posedge sys_clk);
         g = (c == 5'h00 || c == 5'h10) ? 6'h00 : {1'b0, c} - 6'h10;
         check(impedance_scaling_code_ctrl, {c == 5'h00, c == 5'h10, g});
         check({analog_input_ignore, analog_output_to_ref},
               {2{c == 5'h10}});
      end
      // slot 1 mu-law, then robbed frames judged on the pulse history
      wr(VHSR_SLOT_ADDR, 32'h0101);
      wr(VHSR_CTRL_ADDR, 32'h080);
      rx(1, 1, 16'h11A7, 18'h000A7);
      wr(VHSR_CTRL_ADDR, 32'h0C0);
      rx(2, 1, 16'h11A7, 18'h200A6);
      rd(VHSR_STATUS_ADDR, v);
      check(v[1:0], 2'b11);
      rx(2, 1, 16'h11A7, 18'h000A7);
      rx(1, 1, 16'h11A7, 18'h000A7);
      wr(VHSR_CTRL_ADDR, 32'h0C2);
      rx(2, 1, 16'h11A7, 18'h000F2);
      wr(VHSR_CTRL_ADDR, 32'h098);
      rx(1, 2, 16'h11A7, 18'h000A7);
      wr(VHSR_SLOT_ADDR, 32'h0);
      wr(VHSR_CTRL_ADDR, 32'h084);
      rx(1, 1, 16'h8123, 18'h18123);
      rd(VHSR_RXDATA_ADDR, v);
      check(v, 32'h0000_8123);
      // signaling byte after the voice byte, also with the channel idle
      wr(VHSR_SLOT_ADDR, 32'h0101);
      wr(VHSR_CTRL_ADDR, 32'h0A0);
      txf(16, 16'h3C84);
      wr(VHSR_CTRL_ADDR, 32'h120);
      txf(8, 16'h00C4);
      // transmit voice byte carries alternate bit inversion in A-law
      wr(VHSR_CTRL_ADDR, 32'h0A2);
      txf(16, 16'h6984);
      // linear transmit word fills two slots, sign bit first
      wr(VHSR_CTRL_ADDR, 32'h084);
      txf(16, 16'h1234);
      // GCI channel 1 chosen by strap, channel 0 filled with ones
      wr(VHSR_CTRL_ADDR, 32'h081);
      gci_channel_select_lo <= 1'b1;
      rxq.delete();
      n_ctrl = 0;
      m_u.frame(1'b1, 1, 2, 64, 64'hFFFF_FFFF_5A3B_C67E);
      repeat (8) @(posedge sys_clk);
      check(rxq.size(), 2);
      check({rxq[0].word[7:0], rxq[1].word[7:0]}, 16'h5A3B);
      check({gci_monitor_byte, gci_sc_byte, 8'(n_ctrl)}, 24'hC67E01);
      rd(VHSR_STATUS_ADDR, v);
      check(v[23:8], 16'h7EC6);
      summarize();
   end
endmodule // voice_highway_slot_receive_signaling_test
`default_nettype wire
